// ==== shared/iar_defs.svh ====
// Register offsets, field positions, reset values and timing counts
// for the input alarm status block. Included by bare name; no logic here.
`ifndef IAR_DEFS_SVH
`define IAR_DEFS_SVH
// ============================================================
// Register map (device register index, 16-bit data)
`define IAR_ADDR_W 5
`define IAR_OFF_FAILS 5'h04
`define IAR_OFF_ALARMS 5'h05
`define IAR_OFF_CTRL 5'h01
`define IAR_OFF_SHUT 5'h02
`define IAR_OFF_MASK 5'h07
// ============================================================
// Alarm flag positions
`define IAR_BIT_ZERO 15
`define IAR_BIT_COLL 13
`define IAR_BIT_ONE 12
`define IAR_BIT_TWO 11
`define IAR_BIT_CONVGONE 10
`define IAR_BIT_DCLKGONE 9
`define IAR_BIT_FORCE 8
`define IAR_BIT_PAT 7
`define IAR_BIT_PLL 5
`define IAR_BIT_RPAR 4
`define IAR_BIT_FPAR 3
`define IAR_BIT_FRPAR 2
// Control register (offset 1) fields
`define IAR_CTRL_PATEN 15
`define IAR_CTRL_FRPAR 0
// Shutdown enable register (offset 2) fields
`define IAR_SHUT_CONV 14
`define IAR_SHUT_DCLK 13
`define IAR_SHUT_COLL 12
// ============================================================
// Reset values
`define IAR_MASK_RST 16'hffff
`define IAR_SHUT_RST 16'h7000
`define IAR_CTRL_RST 16'h0000
`define IAR_MIDSCALE 16'h8000
`define IAR_PTR_RST 8'h01
// ============================================================
// Timing: a clock is lost after this many ns without an edge
`define IAR_GONE_NS 1000
`define IAR_CLK_NS 10
`define IAR_GONE_CYC ((`IAR_GONE_NS) / (`IAR_CLK_NS))
// Host link clock divider: half period in system clocks
`define IAR_HALF_DIV 4
`endif

// ==== shared/iar_pkg.sv ====
// Types shared by both ends of the input alarm status link.
// Assumes iar_defs.svh is on the include path.
package iar_pkg;
  typedef logic [15:0] iar_word_type;
  typedef enum logic [2:0]
  {
    IAR_IDLE = 3'h1,
    IAR_WAIT = 3'h2,
    IAR_DONE = 3'h4
  } iar_bus_state_type;
endpackage : iar_pkg

// ==== shared/iar_link_if.sv ====
// Link between the data source / register master and the alarm device.
// Plain wires; the bench drives the conversion clock monitor inputs.
`timescale 1ns/100ps
interface iar_link_if;
  logic data_clk;          // Input data clock made by the source
  logic [15:0] data;       // Input data bus
  logic par_r;             // Parity bit for rising-edge data
  logic par_f;             // Parity bit for falling-edge data
  logic frame;             // Frame strobe, parity carrier in frame mode
  logic reg_req;           // Register request toggle
  logic reg_we;            // Register write
  logic [4:0] reg_addr;    // Register index
  logic [15:0] reg_wdata;  // Write data
  logic reg_ack;           // Answer toggle
  logic [15:0] reg_rdata;  // Read data
  modport device (input data_clk, data, par_r, par_f, frame, reg_req, reg_we, reg_addr, reg_wdata,
                  output reg_ack, reg_rdata);
  modport source (output data_clk, data, par_r, par_f, frame, reg_req, reg_we, reg_addr, reg_wdata,
                  input reg_ack, reg_rdata);
endinterface : iar_link_if

// ==== hdl/iar_sync.sv ====
// Two-flop synchroniser for a bundle of levels from another domain.
// Assumes the input is stable long enough to be sampled at least once.
`timescale 1ns/100ps
module iar_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  // Only the second flop is read downstream
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule : iar_sync

// ==== hdl/iar_device.sv ====
// Alarm status registers of the input data interface: bit-fail result,
// sticky alarm flags, output forcing to midscale.
// Assumes link pins are asynchronous; FIFO pointers and PLL lock arrive from the core.
// ============================================================
`timescale 1ns/100ps
`include "iar_defs.svh"
module iar_device (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link to the data source
  iar_link_if.device link,
  // Core side
  input wire logic conv_clk_i,
  input wire logic [7:0] wr_ptr_i,
  input wire logic [7:0] rd_ptr_i,
  input wire logic pll_lock_i,
  input wire logic resync_i,
  input wire logic [15:0] pattern_i,
  // Converter samples
  input wire logic [15:0] sample_a_i,
  input wire logic [15:0] sample_b_i,
  output logic [15:0] out_a_o,
  output logic [15:0] out_b_o,
  output logic shutdown_o
);
  localparam int GONE = `IAR_GONE_CYC;
  // ============================================================
  // Synchronisers: every link pin passes two flops
  logic [15:0] data_s;
  logic [4:0] addr_s;
  logic [15:0] wdata_s;
  logic [7:0] wp_s;
  logic [7:0] rp_s;
  logic dclk_s, par_r_s, par_f_s, frame_s, req_s, we_s, conv_s, lock_s;
  iar_sync #(.W(16)) u_sd (.clk_i(clk_i), .rst_i(rst_i), .d_i(link.data), .q_o(data_s));
  iar_sync #(.W(16)) u_sw (.clk_i(clk_i), .rst_i(rst_i), .d_i(link.reg_wdata), .q_o(wdata_s));
  iar_sync #(.W(5)) u_sa (.clk_i(clk_i), .rst_i(rst_i), .d_i(link.reg_addr), .q_o(addr_s));
  iar_sync #(.W(16)) u_sp (.clk_i(clk_i), .rst_i(rst_i), .d_i({wr_ptr_i, rd_ptr_i}), .q_o({wp_s, rp_s}));
  iar_sync #(.W(8)) u_sc (.clk_i(clk_i), .rst_i(rst_i),
    .d_i({link.data_clk, link.par_r, link.par_f, link.frame, link.reg_req, link.reg_we, conv_clk_i, pll_lock_i}),
    .q_o({dclk_s, par_r_s, par_f_s, frame_s, req_s, we_s, conv_s, lock_s}));
  // ============================================================
  // Edge detection and clock monitors
  logic dclk_q, conv_q, req_q, rise_q, fall_q;
  logic [15:0] dgone_cnt_q, cgone_cnt_q, ptr_q;
  wire dclk_rise = dclk_s & ~dclk_q;
  wire dclk_fall = ~dclk_s & dclk_q;
  wire conv_edge = conv_s ^ conv_q;
  wire req_new = req_s ^ req_q;
  wire dclk_gone = (dgone_cnt_q == 16'(GONE));
  wire conv_gone = (cgone_cnt_q == 16'(GONE));
  // A one-hot step caught mid-move can look empty or colliding, so only a repeated word counts
  wire ptr_stable = (ptr_q == {wp_s, rp_s});
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dclk_q <= 1'b0;
      conv_q <= 1'b0;
      req_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      ptr_q <= 16'h0000;
      dgone_cnt_q <= 16'h0000;
      cgone_cnt_q <= 16'h0000;
    end
    else
    begin
      dclk_q <= dclk_s;
      conv_q <= conv_s;
      req_q <= req_s;
      // Data is judged one cycle after its edge, when a skewed bus has settled
      rise_q <= dclk_rise;
      fall_q <= dclk_fall;
      ptr_q <= {wp_s, rp_s};
      dgone_cnt_q <= (dclk_rise | dclk_fall) ? 16'h0000 : (dclk_gone ? dgone_cnt_q : dgone_cnt_q + 16'h0001);
      cgone_cnt_q <= conv_edge ? 16'h0000 : (conv_gone ? cgone_cnt_q : cgone_cnt_q + 16'h0001);
    end
  end
  // ============================================================
  // Configuration registers
  logic [15:0] ctrl_q, shut_q, mask_q, fails_q, alarm_q;
  wire wr = req_new & we_s;
  wire wr_fails = wr & (addr_s == `IAR_OFF_FAILS);
  wire wr_alarm = wr & (addr_s == `IAR_OFF_ALARMS);
  wire pat_en = ctrl_q[`IAR_CTRL_PATEN];
  wire frame_mode = ctrl_q[`IAR_CTRL_FRPAR];
  // ============================================================
  // Detectors
  wire [15:0] diff = data_s ^ pattern_i;
  wire [15:0] fail_hit = (pat_en & (rise_q | fall_q)) ? diff : 16'h0000;
  wire pat_hit = |fail_hit;
  wire zero_hit = ptr_stable & (wp_s == 8'h00);
  wire coll_hit = ptr_stable & ((wp_s & rp_s) != 8'h00);
  wire one_hit = (({wp_s[6:0], wp_s[7]} & rp_s) != 8'h00) | (({wp_s[0], wp_s[7:1]} & rp_s) != 8'h00);
  wire two_hit = (({wp_s[5:0], wp_s[7:6]} & rp_s) != 8'h00) | (({wp_s[1:0], wp_s[7:2]} & rp_s) != 8'h00);
  wire par_odd = ^data_s;
  wire rpar_hit = rise_q & ~frame_mode & (par_odd != par_r_s);
  wire fpar_hit = fall_q & ~frame_mode & (par_odd != par_f_s);
  wire frpar_hit = rise_q & frame_mode & (par_odd != frame_s);
  wire pll_hit = ~lock_s;
  wire force_hit = conv_gone | dclk_gone | coll_hit;
  logic [15:0] alarm_set;
  always_comb
  begin
    alarm_set = 16'h0000;
    alarm_set[`IAR_BIT_ZERO] = zero_hit & ~resync_i;
    alarm_set[`IAR_BIT_COLL] = coll_hit;
    alarm_set[`IAR_BIT_ONE] = ptr_stable & one_hit & ~coll_hit;
    alarm_set[`IAR_BIT_TWO] = ptr_stable & two_hit & ~one_hit & ~coll_hit;
    alarm_set[`IAR_BIT_CONVGONE] = conv_gone;
    alarm_set[`IAR_BIT_DCLKGONE] = dclk_gone;
    alarm_set[`IAR_BIT_FORCE] = force_hit;
    alarm_set[`IAR_BIT_PAT] = pat_hit;
    alarm_set[`IAR_BIT_PLL] = pll_hit;
    alarm_set[`IAR_BIT_RPAR] = rpar_hit;
    alarm_set[`IAR_BIT_FPAR] = fpar_hit;
    alarm_set[`IAR_BIT_FRPAR] = frpar_hit;
  end
  // Write-to-clear: ones written clear, a new event in the same cycle wins
  wire [15:0] alarm_d = (alarm_q & ~(wr_alarm ? wdata_s : 16'h0000)) | alarm_set;
  wire [15:0] fails_d = (fails_q & ~(wr_fails ? wdata_s : 16'h0000)) | fail_hit;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= `IAR_CTRL_RST;
      shut_q <= `IAR_SHUT_RST;
      mask_q <= `IAR_MASK_RST;
      alarm_q <= 16'h0000;
    end
    else
    begin
      if (wr & (addr_s == `IAR_OFF_CTRL))
        ctrl_q <= wdata_s;
      if (wr & (addr_s == `IAR_OFF_SHUT))
        shut_q <= wdata_s;
      if (wr & (addr_s == `IAR_OFF_MASK))
        mask_q <= wdata_s;
      alarm_q <= alarm_d;
    end
  end
  // Result register has no reset value, as in the real part
  always_ff @(posedge clk_i)
  begin
    fails_q <= fails_d;
  end
  // ============================================================
  // Output shutdown: alarm must be enabled and unmasked
  wire force_ok = alarm_q[`IAR_BIT_FORCE] & ~mask_q[`IAR_BIT_FORCE];
  wire sd_coll = shut_q[`IAR_SHUT_COLL] & alarm_q[`IAR_BIT_COLL] & ~mask_q[`IAR_BIT_COLL];
  wire sd_conv = shut_q[`IAR_SHUT_CONV] & alarm_q[`IAR_BIT_CONVGONE] & ~mask_q[`IAR_BIT_CONVGONE];
  wire sd_dclk = shut_q[`IAR_SHUT_DCLK] & alarm_q[`IAR_BIT_DCLKGONE] & ~mask_q[`IAR_BIT_DCLKGONE];
  wire sd = force_ok & (sd_coll | sd_conv | sd_dclk);
  // ============================================================
  // Register read and answer
  logic [15:0] rdata_mux;
  always_comb
  begin
    case (addr_s)
      `IAR_OFF_FAILS: rdata_mux = fails_q;
      `IAR_OFF_ALARMS: rdata_mux = alarm_q & 16'hbfbc;
      `IAR_OFF_CTRL: rdata_mux = ctrl_q;
      `IAR_OFF_SHUT: rdata_mux = shut_q;
      `IAR_OFF_MASK: rdata_mux = mask_q;
      default: rdata_mux = 16'h0000;
    endcase
  end
  logic ack_q;
  logic [15:0] rdata_q;
  assign link.reg_ack = ack_q;
  assign link.reg_rdata = rdata_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= 16'h0000;
      out_a_o <= 16'h0000;
      out_b_o <= 16'h0000;
      shutdown_o <= 1'b0;
    end
    else
    begin
      if (req_new)
      begin
        ack_q <= ~ack_q;
        rdata_q <= rdata_mux;
      end
      out_a_o <= sd ? `IAR_MIDSCALE : sample_a_i;
      out_b_o <= sd ? `IAR_MIDSCALE : sample_b_i;
      shutdown_o <= sd;
    end
  end
endmodule : iar_device

// ==== hdl/iar_source.sv ====
// Data source and register master: drives the input data clock by a
// divider, data with parity, and forwards Wishbone register accesses.
// Assumes the device answers each request toggle with an ack toggle.
`timescale 1ns/100ps
`include "iar_defs.svh"
module iar_source (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link
  iar_link_if.source link,
  // Data to send
  input wire logic [15:0] tx_data_i,
  input wire logic frame_mode_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [1:0] sel_i,
  input wire logic [15:0] dat_i,
  output logic [15:0] dat_o,
  output logic ack_o
);
  logic [3:0] div_q;
  logic dclk_q, req_q, ack_s, ack_seen_q;
  logic [15:0] data_q, wd_q;
  logic [4:0] adr_q;
  logic we_q;
  iar_pkg::iar_bus_state_type st_q;
  // ============================================================
  // Link clock divider; data and parity change at the clock edges
  wire half = (div_q == 4'(`IAR_HALF_DIV - 1));
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_q <= 4'h0;
      dclk_q <= 1'b0;
      data_q <= 16'h0000;
    end
    else
    begin
      div_q <= half ? 4'h0 : div_q + 4'h1;
      if (half)
      begin
        dclk_q <= ~dclk_q;
        data_q <= tx_data_i;
      end
    end
  end
  assign link.data_clk = dclk_q;
  assign link.data = data_q;
  assign link.par_r = ^data_q;
  assign link.par_f = ^data_q;
  assign link.frame = frame_mode_i ? ^data_q : 1'b0;
  assign link.reg_req = req_q;
  assign link.reg_we = we_q;
  assign link.reg_addr = adr_q;
  assign link.reg_wdata = wd_q;
  // Ack toggle from the device is synchronised
  iar_sync #(.W(1)) u_ack (.clk_i(clk_i), .rst_i(rst_i), .d_i(link.reg_ack), .q_o(ack_s));
  // ============================================================
  // Bus bridge: fields stable before the request toggle, held until ack
  wire start = cyc_i & stb_i & ~ack_o;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= iar_pkg::IAR_IDLE;
      req_q <= 1'b0;
      ack_seen_q <= 1'b0;
      adr_q <= 5'h00;
      wd_q <= 16'h0000;
      we_q <= 1'b0;
      ack_o <= 1'b0;
      dat_o <= 16'h0000;
    end
    else
    begin
      ack_o <= 1'b0;
      case (st_q)
        iar_pkg::IAR_IDLE:
          if (start)
          begin
            adr_q <= adr_i;
            we_q <= we_i;
            wd_q <= dat_i & {{8{sel_i[1]}}, {8{sel_i[0]}}}; // unselected byte lanes go out as zero
            st_q <= iar_pkg::IAR_WAIT;
          end
        iar_pkg::IAR_WAIT:
          if (div_q == 4'h0)
          begin
            req_q <= ~req_q;
            st_q <= iar_pkg::IAR_DONE;
          end
        iar_pkg::IAR_DONE:
          if (ack_s != ack_seen_q)
          begin
            ack_seen_q <= ack_s;
            dat_o <= link.reg_rdata;
            ack_o <= 1'b1;
            st_q <= iar_pkg::IAR_IDLE;
          end
        default: st_q <= iar_pkg::IAR_IDLE;
      endcase
    end
  end
endmodule : iar_source

// ==== testbench/iar_link_sva.sv ====
// Concurrent checks on the link that joins the source and the alarm device.
// Assumes it sees the link wires, the shared clock and the OR of both resets.
`timescale 1ns/100ps
`include "iar_defs.svh"
module iar_link_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link wires
  input wire logic data_clk_i,
  input wire logic [15:0] data_i,
  input wire logic par_r_i,
  input wire logic reg_req_i,
  input wire logic reg_we_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_ack_i,
  input wire logic [15:0] reg_rdata_i
);
  // ============================================================
  // Handshake, data clock and read-back relations
  // An answer carries alarm bits whenever the pending request addresses the alarms; only reads are checked
  wire alarm_rd = !reg_we_i && (reg_addr_i == `IAR_OFF_ALARMS);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Answer toggles must pair one to one with requests
  a_req_single: assert property ($changed(reg_req_i) |-> $past(reg_ack_i) == $past(reg_req_i))
    else $error("request toggled while one was pending");
  a_ack_bounded: assert property ($changed(reg_req_i) |-> ##[1:40] (reg_ack_i == reg_req_i))
    else $error("request not answered in time");
  a_ack_matches: assert property ($changed(reg_ack_i) |-> reg_ack_i == reg_req_i)
    else $error("answer without a pending request");
  a_req_held: assert property ((reg_req_i != reg_ack_i) && ($past(reg_req_i) != $past(reg_ack_i)) |->
      $stable(reg_addr_i) && $stable(reg_we_i) && $stable(reg_wdata_i))
    else $error("request fields moved while pending");
  // Divider gives a four-cycle half period; a slip would skew capture
  a_dclk_half: assert property ($changed(data_clk_i) |=> $stable(data_clk_i) [*3] ##1 $changed(data_clk_i))
    else $error("data clock half period not four cycles");
  a_par_even: assert property ($stable(data_i) && $stable(par_r_i) |-> par_r_i == ^data_i)
    else $error("rising edge parity wrong");
  // Data moving between edges would let the device capture a torn word
  a_data_launch: assert property ($changed(data_i) |-> $changed(data_clk_i))
    else $error("data moved between data clock edges");
  a_force_follows: assert property ($changed(reg_ack_i) && alarm_rd &&
      (reg_rdata_i[`IAR_BIT_COLL] || reg_rdata_i[`IAR_BIT_CONVGONE] || reg_rdata_i[`IAR_BIT_DCLKGONE]) |->
      reg_rdata_i[`IAR_BIT_FORCE])
    else $error("forcing alarm missing with its cause");
  a_rsvd_zero: assert property ($changed(reg_ack_i) && alarm_rd |->
      (reg_rdata_i & 16'h4043) == 16'h0000)
    else $error("reserved alarm bits read nonzero");
endmodule : iar_link_sva

// ==== testbench/tb_top.sv ====
// Testbench: Wishbone calls through the source end, faults forced on the
// device's core inputs. Assumes one shared clock; a source reset stalls the data clock.
`timescale 1ns/100ps
`include "iar_defs.svh"
module tb_top;
  // ============================================================
  // Stimulus and observation
  logic clk_i = 1'b0, dev_rst = 1'b1, src_rst = 1'b1, conv_clk = 1'b0, conv_run = 1'b1;
  logic pll_lock = 1'b1, resync = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, frm = 1'b0, ack, shut;
  logic [7:0] wr_ptr = 8'h10, rd_ptr = 8'h01;
  logic [15:0] pattern = 16'h0000, tx_data = 16'h5a3c, wdat = 16'h0000, rdat, out_a, out_b, v;
  logic [4:0] adr = 5'h00;
  localparam logic [4:0] alm = `IAR_OFF_ALARMS;
  int err_count = 0, n_tests = 0;
  // Pointer cases: zero, two apart, one apart, collision
  logic [7:0] wp [4] = '{8'h00, 8'h10, 8'h08, 8'h04};
  logic [7:0] rp [4] = '{8'h01, 8'h04, 8'h04, 8'h04};
  logic [15:0] fm [4] = '{16'h8000, 16'h3800, 16'h3000, 16'h2100};
  logic [15:0] fe [4] = '{16'h8000, 16'h0800, 16'h1000, 16'h2100};
  // System clock 100 MHz; conversion clock 80 ns, stalls while conv_run is low
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  always #40 if (conv_run) conv_clk = ~conv_clk;
  // ============================================================
  // Both ends face each other; checker watches the wires
  iar_link_if link ();
  iar_source iar_source_inst (.clk_i(clk_i), .rst_i(src_rst), .link(link.source), .tx_data_i(tx_data),
    .frame_mode_i(frm), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(2'h3), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack));
  iar_device iar_device_inst (.clk_i(clk_i), .rst_i(dev_rst), .link(link.device), .conv_clk_i(conv_clk),
    .wr_ptr_i(wr_ptr), .rd_ptr_i(rd_ptr), .pll_lock_i(pll_lock), .resync_i(resync), .pattern_i(pattern),
    .sample_a_i(16'h1234), .sample_b_i(16'h4321), .out_a_o(out_a), .out_b_o(out_b), .shutdown_o(shut));
  iar_link_sva iar_link_sva_inst (.clk_i(clk_i), .rst_i(src_rst | dev_rst), .data_clk_i(link.data_clk),
    .data_i(link.data), .par_r_i(link.par_r), .reg_req_i(link.reg_req), .reg_we_i(link.reg_we),
    .reg_addr_i(link.reg_addr), .reg_wdata_i(link.reg_wdata), .reg_ack_i(link.reg_ack),
    .reg_rdata_i(link.reg_rdata));
  // ============================================================
  // Bus tasks: request held until ack is sampled, then released
  task automatic wb(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    v = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask : check
  task automatic rdc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
    wb(1'b0, a, 16'h0000);
    check(v & m, e);
  endtask : rdc
  task automatic clr(input logic [4:0] a);
    wb(1'b1, a, 16'hffff);
  endtask : clr
  task automatic pause(input int n);
    repeat (n) @(posedge clk_i);
  endtask : pause
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // Watchdog: the sequence needs well under 20000 cycles
  initial
  begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  // ============================================================
  // Main sequence
  initial
  begin
    pause(4);
    dev_rst <= 1'b0;
    src_rst <= 1'b0;
    rdc(`IAR_OFF_MASK, 16'hffff, `IAR_MASK_RST);
    rdc(5'h1f, 16'hffff, 16'h0000);
    pause(150);
    clr(alm);
    pause(20);
    rdc(alm, 16'hffff, 16'h0000);
    // Pointer alarms: set, sticky after the fault goes, cleared by a write
    for (int i = 0; i < 4; i++)
    begin
      wr_ptr <= wp[i];
      rd_ptr <= rp[i];
      pause(10);
      rdc(alm, fm[i], fe[i]);
      wr_ptr <= 8'h10;
      rd_ptr <= 8'h01;
      pause(10);
      rdc(alm, fm[i], fe[i]);
      clr(alm);
      pause(5);
      rdc(alm, 16'hffff, 16'h0000);
    end
    // Resync hides a zero pointer; resync drops only after the pointer settles
    resync <= 1'b1;
    wr_ptr <= 8'h00;
    pause(10);
    rdc(alm, 16'h8000, 16'h0000);
    wr_ptr <= 8'h10;
    pause(5);
    resync <= 1'b0;
    // Collision forces midscale only while enabled and unmasked
    wr_ptr <= 8'h04;
    rd_ptr <= 8'h04;
    wb(1'b1, `IAR_OFF_MASK, 16'hdeff);
    pause(5);
    check({15'h0000, shut}, 16'h0001);
    check(out_a, `IAR_MIDSCALE);
    check(out_b, `IAR_MIDSCALE);
    wb(1'b1, `IAR_OFF_SHUT, 16'h0000);
    clr(alm);
    pause(5);
    check({15'h0000, shut}, 16'h0000);
    rdc(alm, 16'h2100, 16'h2100);
    wr_ptr <= 8'h10;
    rd_ptr <= 8'h01;
    wb(1'b1, `IAR_OFF_SHUT, `IAR_SHUT_RST);
    clr(alm);
    pause(5);
    check({15'h0000, shut}, 16'h0000);
    check(out_a, 16'h1234);
    // Conversion clock stall, restart, clear
    wb(1'b1, `IAR_OFF_MASK, 16'hfaff);
    conv_run = 1'b0;
    pause(200);
    rdc(alm, 16'h0500, 16'h0500);
    check({15'h0000, shut}, 16'h0001);
    check(out_a, `IAR_MIDSCALE);
    conv_run = 1'b1;
    pause(20);
    clr(alm);
    pause(5);
    check({15'h0000, shut}, 16'h0000);
    // Data clock stall: source held in reset with no request pending
    wb(1'b1, `IAR_OFF_MASK, `IAR_MASK_RST);
    if (link.reg_ack === 1'b1)
      rdc(5'h1f, 16'hffff, 16'h0000);
    src_rst <= 1'b1;
    pause(200);
    src_rst <= 1'b0;
    rdc(alm, 16'h0300, 16'h0300);
    pll_lock <= 1'b0;
    pause(5);
    pll_lock <= 1'b1;
    rdc(alm, 16'h0020, 16'h0020);
    // Frame parity: odd-parity word, frame line low then carrying parity
    tx_data <= 16'h5a3d;
    wb(1'b1, `IAR_OFF_CTRL, 16'h0001);
    for (int f = 0; f < 2; f++)
    begin
      frm <= (f == 1);
      pause(20);
      clr(alm);
      pause(20);
      rdc(alm, 16'h001c, (f == 0) ? 16'h0004 : 16'h0000);
    end
    // Pattern check: lines 15 and 0 fail, then a clean pattern
    wb(1'b1, `IAR_OFF_CTRL, 16'h8000);
    for (int k = 0; k < 2; k++)
    begin
      pattern <= (k == 0) ? (tx_data ^ 16'h8001) : tx_data;
      pause(30);
      clr(`IAR_OFF_FAILS);
      clr(alm);
      pause(30);
      rdc(`IAR_OFF_FAILS, 16'hffff, (k == 0) ? 16'h8001 : 16'h0000);
      rdc(alm, 16'h0080, (k == 0) ? 16'h0080 : 16'h0000);
    end
    tally_and_finish();
  end
endmodule : tb_top
